// *** rtl/clk_src_map.svh ***
// Register indices, field positions, reset values and rate limits of the clock source control
`ifndef CLK_SRC_MAP_SVH
`define CLK_SRC_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_SAMPLE_RATE_LO 18'h04e20
`define IDX_SAMPLE_RATE_HI 18'h04e21
`define IDX_SYNC_CONTROL 18'h04e22
`define IDX_ENGINE_STATUS 18'h04e23
`define IDX_CLOCK_OUT_EN 18'h04e8e
`define IDX_CLOCK_OUT_FREQ 18'h04e8f
`define IDX_CLOCK_SOURCE 18'h04ee8
`define IDX_SUPPORTED_SRC 18'h04ee9
`define IDX_OVERSAMPLE 18'h30dbb

// Supported clock source codes, one bit per mode code
`define SUPPORTED_MODES 32'h0000_0029

// Sync control fields
`define SYNC_MASTER_BIT 0
`define SYNC_PLL_BIT 1
`define SYNC_COUNT_LSB 4
`define SYNC_COUNT_MSB 8
`define SYNC_MAX_CARDS 5'h10

// Engine status fields
`define STAT_BUSY_BIT 0
`define STAT_REJECT_BIT 1

// Reset values
`define RST_CLOCK_SOURCE 6'h01
`define RST_SAMPLE_RATE 64'h0000_0000_03b9_aca0
`define RST_OVERSAMPLE 32'h0000_0001
`define RST_SYNC_COUNT 5'h01

// Rate grid and limits in Hz
`define RATE_STEP_HALF 64'h0000_0000_0000_0004
`define RATE_STEP_MASK 64'hffff_ffff_ffff_fff8
`define MIN_RATE_HZ 64'h0000_0000_0000_03e8
`define MAX_RATE_HZ 64'h0000_0000_0773_5940
`define MIN_NATIVE_HZ 64'h0000_0000_02fa_f080

`endif

// *** rtl/clk_src_pkg.sv ***
// Types shared by the clock source control and its rate resolver
package clk_src_pkg;

    typedef enum logic [5:0] {
        internal_pll_source = 6'h01,
        direct_external_source = 6'h08,
        external_reference_pll_source = 6'h20
    } clk_mode_t;

    typedef enum logic [1:0] {
        ref_onboard_osc = 2'h0,
        ref_external_pin = 2'h1,
        ref_sync_bus = 2'h2
    } pll_ref_t;

    typedef enum {
        res_idle,
        res_scale
    } res_state_t;

endpackage

// *** rtl/rate_resolver.sv ***
// Resolves a requested rate to the nearest achievable rate and its oversampling factor
`timescale 1ns/1ps
`include "clk_src_map.svh"

module rate_resolver import clk_src_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic start_i, // Pulse: resolve request_i
    input wire logic [63:0] request_i, // Requested rate in Hz
    output logic busy_o, // Resolution in progress
    output logic done_o, // Pulse: results valid
    output logic [63:0] rate_o, // Nearest achievable rate
    output logic [63:0] conv_o, // Converter clock rate
    output logic [31:0] factor_o // Oversampling factor
);

    res_state_t state_reg;
    logic [63:0] rounded;
    logic [63:0] clamped;

    // Round to the PLL grid, then hold inside the legal range
    always_comb begin
        rounded = (request_i + `RATE_STEP_HALF) & `RATE_STEP_MASK;
        if (request_i > `MAX_RATE_HZ) begin
            clamped = `MAX_RATE_HZ;
        end else if (rounded < `MIN_RATE_HZ) begin
            clamped = `MIN_RATE_HZ;
        end else begin
            clamped = rounded;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= res_idle;
            rate_o <= `RST_SAMPLE_RATE;
            conv_o <= `RST_SAMPLE_RATE;
            factor_o <= `RST_OVERSAMPLE;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                // A new request restarts any resolution in flight
                state_reg <= res_scale;
                rate_o <= clamped;
                conv_o <= clamped;
                factor_o <= `RST_OVERSAMPLE;
            end else begin
                unique case (state_reg)
                    res_idle: begin
                    end
                    res_scale: begin
                        // Doubling keeps the converter at or above its native minimum
                        if (conv_o < `MIN_NATIVE_HZ) begin
                            conv_o <= {conv_o[62:0], 1'b0};
                            factor_o <= {factor_o[30:0], 1'b0};
                        end else begin
                            state_reg <= res_idle;
                            done_o <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign busy_o = (state_reg == res_scale);

endmodule

// *** rtl/sample_clock_source_control.sv ***
// Sample clock source selection, rate programming and clock output control
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "clk_src_map.svh"

module sample_clock_source_control import clk_src_pkg::*; (
    input wire logic clk_i, // System clock, 200 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write enable
    input wire logic [19:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire logic ext_clk_i, // External clock connector input
    input wire logic pll_clk_i, // PLL output clock
    input wire logic sync_clk_i, // Distributed sync clock input
    output logic clk_out_o, // Clock output connector level
    output logic clk_out_oe_o, // Clock output connector drive enable
    output logic sync_clk_o, // Sync clock distribution level
    output logic sync_clk_oe_o, // Sync clock distribution drive enable
    output logic [1:0] pll_ref_sel_o, // PLL reference selection
    output logic pll_bypass_o, // Sample clock taken directly from pin
    output logic [63:0] pll_target_hz_o, // PLL target converter rate
    output logic pll_load_o, // Pulse: load new PLL target
    output logic [31:0] dig_divide_o, // Digital path divide factor
    output logic dig_sample_en_o // Pulse: digital sample slot
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    function automatic logic is_reg(input logic [19:0] adr, input logic [17:0] idx);
        is_reg = (adr[19:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    // Exactly one bit set, and that bit offered in the supported mask
    function automatic logic mode_ok(input logic [31:0] code);
        mode_ok = (code != 32'h0) && ((code & (code - 32'h1)) == 32'h0)
                  && ((code & ~`SUPPORTED_MODES) == 32'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [2:0] pin_raw;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;

    assign pin_raw = {sync_clk_i, pll_clk_i, ext_clk_i};

    generate
        for (genvar g = 0; g < 3; g++) begin : gen_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_meta_reg[g] <= 1'b0;
                    pin_sync_reg[g] <= 1'b0;
                end else begin
                    pin_meta_reg[g] <= pin_raw[g];
                    pin_sync_reg[g] <= pin_meta_reg[g];
                end
            end
        end
    endgenerate

    logic ext_lvl;
    logic pll_lvl;
    assign ext_lvl = pin_sync_reg[0];
    assign pll_lvl = pin_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, dropped the next cycle

    logic ack_reg;
    logic access;
    logic wr_fire;

    assign access = cyc_i && stb_i && !ack_reg;
    assign wr_fire = access && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    assign ack_o = ack_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock source select

    clk_mode_t mode_reg;
    logic reject_reg;
    logic [31:0] mode_wdata;

    assign mode_wdata = merge_bytes({26'h0, mode_reg}, dat_i, sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= clk_mode_t'(`RST_CLOCK_SOURCE);
            reject_reg <= 1'b0;
        end else if (wr_fire && is_reg(adr_i, `IDX_CLOCK_SOURCE)) begin
            if (mode_ok(mode_wdata)) begin
                mode_reg <= clk_mode_t'(mode_wdata[5:0]);
                reject_reg <= 1'b0;
            end else begin
                reject_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample rate request and resolution

    logic [63:0] rate_req_reg;
    logic [63:0] rate_req_next;
    logic rate_start_reg;
    logic res_busy;
    logic res_done;
    logic [63:0] res_rate;
    logic [63:0] res_conv;
    logic [31:0] res_factor;

    // High word is staged; the low-word write launches the PLL update
    always_comb begin
        rate_req_next = rate_req_reg;
        if (wr_fire && is_reg(adr_i, `IDX_SAMPLE_RATE_LO)) begin
            rate_req_next[31:0] = merge_bytes(rate_req_reg[31:0], dat_i, sel_i);
        end
        if (wr_fire && is_reg(adr_i, `IDX_SAMPLE_RATE_HI)) begin
            rate_req_next[63:32] = merge_bytes(rate_req_reg[63:32], dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_req_reg <= `RST_SAMPLE_RATE;
            rate_start_reg <= 1'b0;
        end else begin
            rate_req_reg <= rate_req_next;
            rate_start_reg <= wr_fire && is_reg(adr_i, `IDX_SAMPLE_RATE_LO);
        end
    end

    rate_resolver u_resolver (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(rate_start_reg),
        .request_i(rate_req_reg),
        .busy_o(res_busy),
        .done_o(res_done),
        .rate_o(res_rate),
        .conv_o(res_conv),
        .factor_o(res_factor)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock output enable and sync control

    logic clk_out_en_reg;
    logic sync_master_reg;
    logic sync_pll_reg;
    logic [4:0] sync_count_reg;
    logic [31:0] sync_wdata;
    logic [4:0] sync_count_wr;

    assign sync_wdata = merge_bytes({23'h0, sync_count_reg, 2'h0, sync_pll_reg,
                                     sync_master_reg}, dat_i, sel_i);
    assign sync_count_wr = sync_wdata[`SYNC_COUNT_MSB:`SYNC_COUNT_LSB];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_out_en_reg <= 1'b0;
        end else if (wr_fire && is_reg(adr_i, `IDX_CLOCK_OUT_EN) && sel_i[0]) begin
            clk_out_en_reg <= dat_i[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_master_reg <= 1'b0;
            sync_pll_reg <= 1'b0;
            sync_count_reg <= `RST_SYNC_COUNT;
        end else if (wr_fire && is_reg(adr_i, `IDX_SYNC_CONTROL)) begin
            sync_master_reg <= sync_wdata[`SYNC_MASTER_BIT];
            sync_pll_reg <= sync_wdata[`SYNC_PLL_BIT];
            // Group sizes outside one to sixteen cards keep the old count
            if (sync_count_wr != 5'h0 && sync_count_wr <= `SYNC_MAX_CARDS) begin
                sync_count_reg <= sync_count_wr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source routing and PLL configuration

    logic direct_mode;
    logic [31:0] eff_factor;
    logic [63:0] eff_conv;

    assign direct_mode = (mode_reg == direct_external_source);
    // No synthesis and no oversampling on a directly fed clock
    assign eff_factor = direct_mode ? `RST_OVERSAMPLE : res_factor;
    assign eff_conv = direct_mode ? 64'h0 : res_conv;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_ref_sel_o <= ref_onboard_osc;
            pll_bypass_o <= 1'b0;
        end else begin
            pll_bypass_o <= direct_mode;
            if (sync_pll_reg && !direct_mode) begin
                pll_ref_sel_o <= ref_sync_bus;
            end else if (mode_reg == external_reference_pll_source) begin
                pll_ref_sel_o <= ref_external_pin;
            end else begin
                pll_ref_sel_o <= ref_onboard_osc;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_target_hz_o <= `RST_SAMPLE_RATE;
            pll_load_o <= 1'b0;
        end else begin
            pll_load_o <= res_done;
            if (res_done) begin
                // Converter is programmed at the oversampled rate
                pll_target_hz_o <= res_conv;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample clock, clock output and digital sample slots

    logic sample_lvl;
    logic sample_prev_reg;
    logic [31:0] slot_cnt_reg;

    // Converter clock itself goes out, not the slower digital rate
    assign sample_lvl = direct_mode ? ext_lvl : pll_lvl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_out_o <= 1'b0;
            clk_out_oe_o <= 1'b0;
        end else begin
            clk_out_oe_o <= clk_out_en_reg;
            clk_out_o <= clk_out_en_reg && sample_lvl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_clk_o <= 1'b0;
            sync_clk_oe_o <= 1'b0;
        end else begin
            sync_clk_oe_o <= sync_master_reg;
            sync_clk_o <= sync_master_reg && sample_lvl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_prev_reg <= 1'b0;
        end else begin
            sample_prev_reg <= sample_lvl;
        end
    end

    // One slot per factor converter edges keeps the digital path at the set rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt_reg <= 32'h0;
            dig_sample_en_o <= 1'b0;
            dig_divide_o <= `RST_OVERSAMPLE;
        end else begin
            dig_divide_o <= eff_factor;
            dig_sample_en_o <= 1'b0;
            if (sample_lvl && !sample_prev_reg) begin
                if (slot_cnt_reg + 32'h1 >= eff_factor) begin
                    slot_cnt_reg <= 32'h0;
                    dig_sample_en_o <= 1'b1;
                end else begin
                    slot_cnt_reg <= slot_cnt_reg + 32'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        if (is_reg(adr_i, `IDX_SAMPLE_RATE_LO)) begin
            rd_mux = res_rate[31:0];
        end else if (is_reg(adr_i, `IDX_SAMPLE_RATE_HI)) begin
            rd_mux = res_rate[63:32];
        end else if (is_reg(adr_i, `IDX_CLOCK_SOURCE)) begin
            rd_mux = {26'h0, mode_reg};
        end else if (is_reg(adr_i, `IDX_SUPPORTED_SRC)) begin
            rd_mux = `SUPPORTED_MODES;
        end else if (is_reg(adr_i, `IDX_CLOCK_OUT_EN)) begin
            rd_mux = {31'h0, clk_out_en_reg};
        end else if (is_reg(adr_i, `IDX_CLOCK_OUT_FREQ)) begin
            rd_mux = eff_conv[31:0];
        end else if (is_reg(adr_i, `IDX_OVERSAMPLE)) begin
            rd_mux = eff_factor;
        end else if (is_reg(adr_i, `IDX_SYNC_CONTROL)) begin
            rd_mux = {23'h0, sync_count_reg, 2'h0, sync_pll_reg, sync_master_reg};
        end else if (is_reg(adr_i, `IDX_ENGINE_STATUS)) begin
            rd_mux[`STAT_BUSY_BIT] = res_busy || rate_start_reg;
            rd_mux[`STAT_REJECT_BIT] = reject_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (access && !we_i) begin
            dat_o <= rd_mux;
        end else begin
            dat_o <= 32'h0;
        end
    end

endmodule

// *** tb/clock_partner.sv ***
// Behavioural far-side clock sources: external pin, PLL output and sync bus
`timescale 1ns/1ps

module clock_partner (
    input wire logic slow_i, // Stretch all periods threefold
    output logic ext_clk_o, // External connector clock
    output logic pll_clk_o, // PLL output clock
    output logic sync_clk_o // Master card sync clock
);
    // Half periods unrelated to the 5 ns system clock
    initial begin
        ext_clk_o = 1'b0;
        forever #(slow_i ? 34.5 : 11.5) ext_clk_o = ~ext_clk_o;
    end
    initial begin
        pll_clk_o = 1'b0;
        forever #(slow_i ? 25.5 : 8.5) pll_clk_o = ~pll_clk_o;
    end
    initial begin
        sync_clk_o = 1'b0;
        forever #(slow_i ? 46.5 : 15.5) sync_clk_o = ~sync_clk_o;
    end
endmodule

// *** tb/clk_src_sva.sv ***
// Port assertions for the sample clock source control
`timescale 1ns/1ps
`include "clk_src_map.svh"

module clk_src_sva (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic cyc_i, // Cycle
    input wire logic stb_i, // Strobe
    input wire logic we_i, // Write
    input wire logic [19:0] adr_i, // Address
    input wire logic [3:0] sel_i, // Selects
    input wire logic [31:0] dat_i, // Write data
    input wire logic [31:0] dat_o, // Read data
    input wire logic ack_o, // Ack
    input wire logic clk_out_o, // Out level
    input wire logic clk_out_oe_o, // Out enable
    input wire logic pll_bypass_o, // Bypass
    input wire logic [1:0] pll_ref_sel_o, // Reference
    input wire logic [63:0] pll_target_hz_o, // Converter rate
    input wire logic pll_load_o, // Load
    input wire logic [31:0] dig_divide_o, // Divide
    input wire logic dig_sample_en_o // Slot
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic wr_src;
    logic wr_oe;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_src = req && we_i && sel_i[0] && adr_i == {`IDX_CLOCK_SOURCE, 2'b00};
    assign wr_oe = req && we_i && sel_i[0] && adr_i == {`IDX_CLOCK_OUT_EN, 2'b00};
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_cause: assert property (ack_o |-> $past(req))
        else $error("ack without request");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_pll_internal: assert property (wr_src && dat_i == 32'h1 |-> ##[1:3] !pll_bypass_o)
        else $error("internal mode still bypassed");
    a_direct_bypass: assert property (wr_src && dat_i == 32'h8 |-> ##[1:3] pll_bypass_o)
        else $error("direct mode not bypassed");
    a_pll_extref: assert property (wr_src && dat_i == 32'h20 |->
        ##[1:3] (!pll_bypass_o && pll_ref_sel_o != 2'h0))
        else $error("external reference not routed to PLL");
    a_oe_on: assert property (wr_oe && dat_i[0] |-> ##[1:2] clk_out_oe_o)
        else $error("clock output not enabled");
    a_oe_off: assert property (wr_oe && !dat_i[0] |-> ##[1:2] !clk_out_oe_o)
        else $error("clock output not tristated");
    a_tristate_low: assert property (!clk_out_oe_o |-> !clk_out_o)
        else $error("output level while tristated");
    a_load_pulse: assert property (pll_load_o |=> !pll_load_o)
        else $error("load pulse too long");
    a_target_range: assert property (pll_load_o |->
        pll_target_hz_o >= `MIN_NATIVE_HZ && pll_target_hz_o <= `MAX_RATE_HZ)
        else $error("converter rate out of range");
    a_slot_spacing: assert property (dig_sample_en_o && dig_divide_o > 32'h1
        |=> !dig_sample_en_o)
        else $error("slots too close while oversampling");
    c_direct: cover property (wr_src ##[1:3] pll_bypass_o);
    c_oversample: cover property (pll_load_o && dig_divide_o > 32'h1);
    c_out_toggle: cover property (clk_out_oe_o && $changed(clk_out_o));
endmodule

bind sample_clock_source_control clk_src_sva clk_src_sva_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .clk_out_o(clk_out_o), .clk_out_oe_o(clk_out_oe_o), .pll_bypass_o(pll_bypass_o),
    .pll_ref_sel_o(pll_ref_sel_o), .pll_target_hz_o(pll_target_hz_o),
    .pll_load_o(pll_load_o), .dig_divide_o(dig_divide_o), .dig_sample_en_o(dig_sample_en_o)
);

// *** tb/tb_top.sv ***
// Self-checking bench for the sample clock source control
`timescale 1ns/1ps
`include "clk_src_map.svh"
`define chk(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb_top import clk_src_pkg::*; ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, slow = 1'b0;
    logic [19:0] adr_i = 20'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd, dig_divide_o;
    logic ack_o, ext_clk, pll_clk, sync_clk, clk_out_o, clk_out_oe_o, sync_clk_o;
    logic sync_clk_oe_o, pll_bypass_o, pll_load_o, dig_sample_en_o;
    logic [1:0] pll_ref_sel_o;
    logic [63:0] pll_target_hz_o;
    int mismatches = 0;
    int check_count = 0;
    logic [17:0] ridx [6] = '{`IDX_CLOCK_SOURCE, `IDX_SAMPLE_RATE_LO, `IDX_SAMPLE_RATE_HI,
        `IDX_OVERSAMPLE, `IDX_CLOCK_OUT_EN, `IDX_CLOCK_OUT_FREQ};
    logic [31:0] rval [6] = '{32'h1, 32'h03b9_aca0, 32'h0, 32'h1, 32'h0, 32'h03b9_aca0};
    logic [63:0] corner [6] = '{64'h3e3, 64'h3e8, 64'h2faf07b, 64'h2faf07c, 64'h7735944,
        64'h1_0000_0000};
    logic [31:0] bad [4] = '{32'h0, 32'h2, 32'h9, 32'h21};

    sample_clock_source_control sample_clock_source_control_i (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .ext_clk_i(ext_clk), .pll_clk_i(pll_clk), .sync_clk_i(sync_clk), .clk_out_o,
        .clk_out_oe_o, .sync_clk_o, .sync_clk_oe_o, .pll_ref_sel_o, .pll_bypass_o,
        .pll_target_hz_o, .pll_load_o, .dig_divide_o, .dig_sample_en_o);
    clock_partner clock_partner_i (.slow_i(slow), .ext_clk_o(ext_clk), .pll_clk_o(pll_clk),
        .sync_clk_o(sync_clk));

    initial forever #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one idle cycle after the ack
    task automatic wb(input logic [17:0] idx, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hf;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        if (ack_o !== 1'b1) begin
            `chk("ack", 1'b1, ack_o)
            end_of_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input string nm, input logic [17:0] idx, input logic [31:0] e);
        wb(idx, 1'b0, 32'h0);
        `chk(nm, e, rd)
    endtask

    function automatic logic [63:0] exp_rate(input logic [63:0] r);
        logic [63:0] v;
        v = (r + 64'h4) & `RATE_STEP_MASK;
        if (v < `MIN_RATE_HZ) v = `MIN_RATE_HZ;
        if (v > `MAX_RATE_HZ) v = `MAX_RATE_HZ;
        return v;
    endfunction

    function automatic logic [31:0] exp_factor(input logic [63:0] v);
        logic [31:0] f;
        f = 32'h1;
        while (v * f < `MIN_NATIVE_HZ) f = f << 1;
        return f;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic rate_case(input logic [63:0] r);
        logic [63:0] v;
        int n;
        v = exp_rate(r);
        wb(`IDX_SAMPLE_RATE_HI, 1'b1, r[63:32]);
        wb(`IDX_SAMPLE_RATE_LO, 1'b1, r[31:0]);
        n = 0;
        do begin
            wb(`IDX_ENGINE_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 64);
        if (rd[0] !== 1'b0) begin
            `chk("busy", 1'b0, rd[0])
            end_of_test();
        end
        rchk("rate lo", `IDX_SAMPLE_RATE_LO, v[31:0]);
        rchk("rate hi", `IDX_SAMPLE_RATE_HI, v[63:32]);
        rchk("factor", `IDX_OVERSAMPLE, exp_factor(v));
        rchk("out freq", `IDX_CLOCK_OUT_FREQ, 32'(v * exp_factor(v)));
        `chk("divide", exp_factor(v), dig_divide_o)
        `chk("target", v * exp_factor(v), pll_target_hz_o)
    endtask

    task automatic mode_case(input clk_mode_t m);
        int chg;
        int sl;
        logic last;
        slow <= 1'($urandom_range(1));
        wb(`IDX_CLOCK_SOURCE, 1'b1, {26'h0, m});
        rchk("source", `IDX_CLOCK_SOURCE, {26'h0, m});
        `chk("bypass", m == direct_external_source, pll_bypass_o)
        if (m != direct_external_source) begin
            `chk("ref", {1'b0, m == external_reference_pll_source}, pll_ref_sel_o)
        end else begin
            rchk("freq", `IDX_CLOCK_OUT_FREQ, 32'h0);
            rchk("factor", `IDX_OVERSAMPLE, 32'h1);
        end
        wb(`IDX_CLOCK_OUT_EN, 1'b1, 32'h1);
        chg = 0;
        sl = 0;
        last = clk_out_o;
        repeat (60) begin
            @(posedge clk_i);
            chg += int'(clk_out_o !== last);
            sl += int'(dig_sample_en_o === 1'b1);
            last = clk_out_o;
        end
        `chk("oe", 1'b1, clk_out_oe_o)
        `chk("toggling", 1'b1, chg > 0)
        // Only the internal case runs at a 1 kHz grid rate, far too slow for a slot here
        `chk("slots", m != internal_pll_source, sl > 0)
        wb(`IDX_CLOCK_OUT_EN, 1'b1, 32'h0);
        `chk("oe off", 1'b0, clk_out_oe_o)
        `chk("level off", 1'b0, clk_out_o)
    endtask

    task automatic reject_case(input logic [31:0] d);
        wb(`IDX_CLOCK_SOURCE, 1'b1, d);
        rchk("kept", `IDX_CLOCK_SOURCE, 32'h1);
        rchk("reject", `IDX_ENGINE_STATUS, 32'h2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(21));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ridx[i]) rchk("reset", ridx[i], rval[i]);
        wb(`IDX_SUPPORTED_SRC, 1'b1, 32'h0);
        rchk("supported", `IDX_SUPPORTED_SRC, 32'h29);
        $display("test reset values done");
        // Reference frequency lives in the driver, set before any rate below
        mode_case(external_reference_pll_source);
        rate_case(64'h0098_9680);
        rate_case(64'h3e3);
        mode_case(direct_external_source);
        mode_case(internal_pll_source);
        $display("test source modes done");
        foreach (bad[i]) reject_case(bad[i]);
        reject_case($urandom | 32'h6);
        $display("test rejected codes done");
        foreach (corner[i]) rate_case(corner[i]);
        repeat (6) rate_case({32'h0, $urandom_range(32'h0bebc200)});
        $display("test rates done");
        wb(`IDX_SYNC_CONTROL, 1'b1, 32'h0000_0103);
        rchk("sync", `IDX_SYNC_CONTROL, 32'h0000_0103);
        `chk("sync oe", 1'b1, sync_clk_oe_o)
        `chk("ref sync", 2'h2, pll_ref_sel_o)
        wb(`IDX_SYNC_CONTROL, 1'b1, 32'h0000_0110);
        rchk("count", `IDX_SYNC_CONTROL, 32'h0000_0100);
        `chk("sync oe off", 1'b0, sync_clk_oe_o)
        `chk("sync level off", 1'b0, sync_clk_o)
        `chk("ref back", 2'h0, pll_ref_sel_o)
        wb(18'h00123, 1'b1, 32'hffff_ffff);
        rchk("unmapped", 18'h00123, 32'h0);
        rchk("source", `IDX_CLOCK_SOURCE, 32'h1);
        $display("test sync and unmapped done");
        end_of_test();
    end
endmodule
